// ---- hw/pc_endian_mode_state.sv ----
// Contract
// - Memory byte order is caught once the strap synchroniser has filled after reset release; 0 little, 1 big.
// - Load/store byte order is memory order XOR flip request.
// - Flip request only when flip bit set and in user mode.
// - Linked load sets reservation flag; conditional store tests it.
// - Conflicting store or exception return clears the reservation flag.
// - Without new target, PC advances 2 for compressed, else 4.
// - Taken branch target loads when the delay-slot instruction retires.
// - One-bit code select: 0 wide instructions, 1 compressed.
// - Link or trap stores upper PC bits combined with code select.
// - PC is a full 32-bit address, all bits significant.
// - Narrow architecture holds narrow float register mode at 0.
// - Delay-slot flag set only for instructions executed in a slot.
// - A trap stops the instruction's later effects at once, save the exception-return reservation clear and the link-fail status bit.
// - Late results write the destination at the next instruction time.
`timescale 1ns/1ns
`default_nettype none
module pc_endian_mode_state #(
    parameter bit WIDE_ARCH = 1'b0
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Strap pin.
    input wire logic byte_order_strap,
    // Instruction retire interface from the pipeline.
    input wire logic retire,
    input wire logic retire_compressed,
    input wire logic branch_taken,
    input wire logic [31:0] branch_target,
    input wire logic link_write,
    input wire logic set_code_select,
    input wire logic new_code_select,
    input wire logic linked_load,
    input wire logic cond_store,
    input wire logic store_conflict,
    input wire logic exc_return,
    input wire logic [31:0] exc_return_pc,
    input wire logic raise_trap,
    input wire logic [4:0] trap_type,
    input wire logic [31:0] trap_vector,
    input wire logic late_result,
    input wire logic [4:0] late_dest,
    // State outputs.
    output logic [31:0] pc,
    output logic memory_byte_order_big,
    output logic access_byte_order_big,
    output logic byte_order_flip_request,
    output logic link_reservation_flag,
    output logic cond_store_ok,
    output logic compressed_code_select,
    output logic narrow_float_regs_mode,
    output logic in_delay_slot_flag,
    output logic [31:0] restart_value,
    output logic restart_valid,
    output logic late_write_en,
    output logic [4:0] late_write_dest,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Strap synchroniser and reset capture.

    logic strap_meta_q, strap_sync_q, strap_taken_q, mem_big_q;
    logic [1:0] settle_q;

    // Two flops bring the strap into the clock domain; settle_q marks when they hold the pin.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_meta_q <= 1'b0;
            strap_sync_q <= 1'b0;
            settle_q <= 2'h0;
        end else begin
            strap_meta_q <= byte_order_strap;
            strap_sync_q <= strap_meta_q;
            settle_q <= {settle_q[0], 1'b1};
        end
    end

    // The order is captured once the synchroniser has filled, so the reset value never leaks.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_taken_q <= 1'b0;
            mem_big_q <= pc_state_pkg::ORDER_LITTLE;
        end else if (!strap_taken_q && settle_q[1]) begin
            strap_taken_q <= 1'b1;
            mem_big_q <= strap_sync_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB registers.

    logic [3:0] ctrl_q;
    logic [pc_state_pkg::IRQ_W-1:0] irq_status_q, irq_mask_q, irq_event;
    logic [31:0] rdata_d, rdata_q;
    logic ready_q, err_q;
    logic [4:0] trap_type_q;

    // Writes and the clear on read act at the access edge, where pready is seen high.
    wire setup = psel && !penable;
    wire access = psel && penable && ready_q;
    wire wr_ctrl = access && pwrite && (paddr == pc_state_pkg::OFF_CTRL);
    wire wr_mask = access && pwrite && (paddr == pc_state_pkg::OFF_IRQ_MASK);
    wire rd_status = access && !pwrite && (paddr == pc_state_pkg::OFF_IRQ_STATUS);
    wire mapped = (paddr == pc_state_pkg::OFF_CTRL) || (paddr == pc_state_pkg::OFF_STATE)
        || (paddr == pc_state_pkg::OFF_PC) || (paddr == pc_state_pkg::OFF_RESTART)
        || (paddr == pc_state_pkg::OFF_TRAP) || (paddr == pc_state_pkg::OFF_IRQ_STATUS)
        || (paddr == pc_state_pkg::OFF_IRQ_MASK);

    // Derived byte order and float mode decode.
    wire flip_d = ctrl_q[pc_state_pkg::CTRL_FLIP_BIT]
        && ctrl_q[pc_state_pkg::CTRL_USER_MODE];
    wire access_big_d = mem_big_q ^ flip_d;
    wire float_narrow_d = (WIDE_ARCH && ctrl_q[pc_state_pkg::CTRL_COMPAT])
        ? ctrl_q[pc_state_pkg::CTRL_WIDTH_BIT]
        : 1'b0;

    // Read data selection.
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (paddr)
            pc_state_pkg::OFF_CTRL: rdata_d = {28'h000_0000, ctrl_q};
            pc_state_pkg::OFF_STATE: rdata_d = {26'h000_0000, in_delay_slot_flag,
                compressed_code_select, link_reservation_flag, access_big_d,
                flip_d, mem_big_q};
            pc_state_pkg::OFF_PC: rdata_d = pc;
            pc_state_pkg::OFF_RESTART: rdata_d = restart_value;
            pc_state_pkg::OFF_TRAP: rdata_d = {27'h000_0000, trap_type_q};
            pc_state_pkg::OFF_IRQ_STATUS: rdata_d = {30'h0000_0000, irq_status_q};
            pc_state_pkg::OFF_IRQ_MASK: rdata_d = {30'h0000_0000, irq_mask_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // Bus answer one cycle after setup, at the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ready_q <= setup;
            err_q <= setup && !mapped;
            rdata_q <= setup && !pwrite ? rdata_d : 32'h0000_0000;
        end
    end

    // Writable control and mask registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 4'h0;
            irq_mask_q <= '0;
        end else begin
            if (wr_ctrl) ctrl_q <= pwdata[3:0];
            if (wr_mask) irq_mask_q <= pwdata[pc_state_pkg::IRQ_W-1:0];
        end
    end

    // Sticky status; a read clears, but a new event wins.
    assign irq_event[pc_state_pkg::IRQ_TRAP] = raise_trap;
    assign irq_event[pc_state_pkg::IRQ_LINK_FAIL] = retire && cond_store
        && !link_reservation_flag;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) irq_status_q <= '0;
        else irq_status_q <= (rd_status ? '0 : irq_status_q) | irq_event;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Program counter, slot state and architectural bits.

    pc_state_pkg::slot_state_t slot_q, slot_d;
    logic [31:0] pending_target_q, pc_d, step;
    logic code_sel_d, resv_d;

    assign step = compressed_code_select ? pc_state_pkg::STEP_NARROW
        : pc_state_pkg::STEP_WIDE;

    // Next program counter and slot state.
    always_comb begin
        pc_d = pc;
        slot_d = slot_q;
        if (raise_trap) begin
            pc_d = trap_vector;
            slot_d = pc_state_pkg::SLOT_TRAP;
        end else if (retire) begin
            case (slot_q)
                pc_state_pkg::SLOT_DELAY: begin
                    pc_d = pending_target_q;
                    slot_d = pc_state_pkg::SLOT_SEQ;
                end
                default: begin
                    if (exc_return) pc_d = exc_return_pc;
                    else pc_d = pc + step;
                    slot_d = (branch_taken && !exc_return) ? pc_state_pkg::SLOT_DELAY
                        : pc_state_pkg::SLOT_SEQ;
                end
            endcase
        end
    end

    // Code select and reservation next values.
    always_comb begin
        code_sel_d = compressed_code_select;
        resv_d = link_reservation_flag;
        if (retire && !raise_trap && set_code_select)
            code_sel_d = new_code_select;
        if (retire && !raise_trap && linked_load) resv_d = 1'b1;
        if (store_conflict || (retire && exc_return)) resv_d = 1'b0;
    end

    // State registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= pc_state_pkg::PC_RESET;
            slot_q <= pc_state_pkg::SLOT_SEQ;
            pending_target_q <= pc_state_pkg::PC_RESET;
            compressed_code_select <= pc_state_pkg::CODE_SELECT_RESET;
            link_reservation_flag <= pc_state_pkg::RESERVATION_RESET;
        end else begin
            pc <= pc_d;
            slot_q <= slot_d;
            if (retire && branch_taken && slot_q != pc_state_pkg::SLOT_DELAY)
                pending_target_q <= branch_target;
            compressed_code_select <= code_sel_d;
            link_reservation_flag <= resv_d;
        end
    end

    // Restart value, trap record, late write and outputs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_value <= 32'h0000_0000;
            restart_valid <= 1'b0;
            trap_type_q <= 5'h00;
            cond_store_ok <= 1'b0;
            late_write_en <= 1'b0;
            late_write_dest <= 5'h00;
            in_delay_slot_flag <= 1'b0;
            memory_byte_order_big <= pc_state_pkg::ORDER_LITTLE;
            access_byte_order_big <= pc_state_pkg::ORDER_LITTLE;
            byte_order_flip_request <= 1'b0;
            narrow_float_regs_mode <= 1'b0;
            irq <= 1'b0;
        end else begin
            restart_valid <= raise_trap || (retire && link_write);
            if (raise_trap)
                restart_value <= {pc[31:1], compressed_code_select};
            else if (retire && link_write)
                restart_value <= {pc_d[31:1] + 31'(step[2:1]),
                    compressed_code_select};
            if (raise_trap) trap_type_q <= trap_type;
            cond_store_ok <= retire && cond_store && link_reservation_flag
                && !raise_trap;
            late_write_en <= retire && late_result && !raise_trap;
            late_write_dest <= late_dest;
            in_delay_slot_flag <= (slot_d == pc_state_pkg::SLOT_DELAY);
            memory_byte_order_big <= mem_big_q;
            access_byte_order_big <= access_big_d;
            byte_order_flip_request <= flip_d;
            narrow_float_regs_mode <= float_narrow_d;
            irq <= |(irq_status_q & irq_mask_q);
        end
    end

    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    sequence taken_branch_s;
        retire && branch_taken && !raise_trap && slot_q == pc_state_pkg::SLOT_SEQ
            && !exc_return;
    endsequence

    AST_FLIP_USER: assert property (@(posedge pclk) disable iff (!presetn)
        byte_order_flip_request |-> $past(ctrl_q[pc_state_pkg::CTRL_USER_MODE]))
        else $error("Flip request outside user mode.");
    AST_ACCESS_XOR: assert property (@(posedge pclk) disable iff (!presetn)
        access_byte_order_big == (memory_byte_order_big ^ byte_order_flip_request))
        else $error("Access byte order is not the XOR.");
    AST_LL_SET: assert property (@(posedge pclk) disable iff (!presetn)
        retire && linked_load && !raise_trap && !store_conflict && !exc_return
        |=> link_reservation_flag)
        else $error("Linked load did not set reservation.");
    AST_ERET_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        retire && exc_return |=> !link_reservation_flag)
        else $error("Exception return left reservation set.");
    AST_PC_STEP: assert property (@(posedge pclk) disable iff (!presetn)
        retire && !raise_trap && !exc_return && slot_q == pc_state_pkg::SLOT_SEQ
        |=> pc == $past(pc) + $past(step))
        else $error("Program counter step wrong.");
    sequence delay_retire_s;
        retire && !raise_trap && slot_q == pc_state_pkg::SLOT_DELAY;
    endsequence

    AST_TARGET_HELD: assert property (@(posedge pclk) disable iff (!presetn)
        taken_branch_s |=> pending_target_q == $past(branch_target))
        else $error("Branch target not captured.");
    AST_DELAY_TARGET: assert property (@(posedge pclk) disable iff (!presetn)
        delay_retire_s |=> pc == $past(pending_target_q))
        else $error("Branch target not loaded after delay slot.");
    AST_SLOT_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        taken_branch_s |=> in_delay_slot_flag)
        else $error("Delay-slot flag missing.");
    AST_TRAP_PC: assert property (@(posedge pclk) disable iff (!presetn)
        raise_trap |=> pc == $past(trap_vector) && restart_valid
        && !late_write_en)
        else $error("Trap did not redirect cleanly.");
    AST_NARROW_FP: assert property (@(posedge pclk) disable iff (!presetn)
        narrow_float_regs_mode |-> WIDE_ARCH && $past(ctrl_q[pc_state_pkg::CTRL_COMPAT]))
        else $error("Float mode not held at zero.");

endmodule : pc_endian_mode_state
`default_nettype wire

// ---- hw/pc_state_pkg.sv ----
package pc_state_pkg;

    // Address and word widths.
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;

    // Program counter steps for the two instruction sizes.
    localparam logic [31:0] STEP_NARROW = 32'h0000_0002;
    localparam logic [31:0] STEP_WIDE = 32'h0000_0004;

    // Reset values of the architectural state.
    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    localparam logic RESERVATION_RESET = 1'b0;
    localparam logic CODE_SELECT_RESET = 1'b0;

    // Byte order encodings.
    localparam logic ORDER_LITTLE = 1'b0;
    localparam logic ORDER_BIG = 1'b1;

    // APB register offsets.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATE = 8'h04;
    localparam logic [7:0] OFF_PC = 8'h08;
    localparam logic [7:0] OFF_RESTART = 8'h0C;
    localparam logic [7:0] OFF_TRAP = 8'h10;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

    // Control register field positions.
    localparam int CTRL_FLIP_BIT = 0;
    localparam int CTRL_USER_MODE = 1;
    localparam int CTRL_WIDTH_BIT = 2;
    localparam int CTRL_COMPAT = 3;

    // Interrupt status bit positions.
    localparam int IRQ_TRAP = 0;
    localparam int IRQ_LINK_FAIL = 1;
    localparam int IRQ_W = 2;

    // Pipeline slot states.
    typedef enum logic [1:0] {
        SLOT_SEQ = 2'b00,
        SLOT_DELAY = 2'b01,
        SLOT_TRAP = 2'b10
    } slot_state_t;

endpackage : pc_state_pkg

// ---- verification/test_pc_endian_mode_state.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_pc_endian_mode_state;
    // Bus, strap and pipeline stimulus, and observed outputs.
    logic pclk, presetn, psel, penable, pwrite, strap, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, tgt, erpc, tvec, pc, rv, v;
    logic retire, br, lw, scs, ncs, ll, cs, sc, er, tr, lr;
    logic mbig, abig, flip, resv, csok, code, narrow, dly, rvld, lwe, irq, wnarrow;
    logic [4:0] ttype, ldst, lwd;
    // Reference model state.
    logic [31:0] e_pc, e_tgt;
    logic e_pend, e_dly, e_resv, e_code;
    logic [1:0] e_st, e_mask;
    int err_count, n_tests, cyc, k;

    pc_endian_mode_state #(.WIDE_ARCH(1'b0)) pc_endian_mode_state_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .byte_order_strap(strap), .retire(retire), .retire_compressed(1'b0),
        .branch_taken(br), .branch_target(tgt), .link_write(lw), .set_code_select(scs),
        .new_code_select(ncs), .linked_load(ll), .cond_store(cs), .store_conflict(sc),
        .exc_return(er), .exc_return_pc(erpc), .raise_trap(tr), .trap_type(ttype),
        .trap_vector(tvec), .late_result(lr), .late_dest(ldst), .pc(pc),
        .memory_byte_order_big(mbig), .access_byte_order_big(abig),
        .byte_order_flip_request(flip), .link_reservation_flag(resv), .cond_store_ok(csok),
        .compressed_code_select(code), .narrow_float_regs_mode(narrow),
        .in_delay_slot_flag(dly), .restart_value(rv), .restart_valid(rvld),
        .late_write_en(lwe), .late_write_dest(lwd), .irq(irq));

    // A second instance on the wide architecture exercises the compatibility mode.
    pc_endian_mode_state #(.WIDE_ARCH(1'b1)) pc_endian_mode_state_wide_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
        .byte_order_strap(strap), .retire(retire), .retire_compressed(1'b0),
        .branch_taken(br), .branch_target(tgt), .link_write(lw), .set_code_select(scs),
        .new_code_select(ncs), .linked_load(ll), .cond_store(cs), .store_conflict(sc),
        .exc_return(er), .exc_return_pc(erpc), .raise_trap(tr), .trap_type(ttype),
        .trap_vector(tvec), .late_result(lr), .late_dest(ldst), .pc(),
        .memory_byte_order_big(), .access_byte_order_big(),
        .byte_order_flip_request(), .link_reservation_flag(), .cond_store_ok(),
        .compressed_code_select(), .narrow_float_regs_mode(wnarrow),
        .in_delay_slot_flag(), .restart_value(), .restart_valid(),
        .late_write_en(), .late_write_dest(), .irq());

    ////////////////////////////////////////////////////////////////////////////////
    // Free-running clock and a cycle ceiling that cuts a hang short.
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compares one value and reports a mismatch at once.
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Prints the verdict and ends the run.
    task automatic stop_test;
        if (err_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    // One APB transfer; the request stands until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Interrupt level follows status and mask after the flops settle.
    task automatic chk_irq;
        repeat (3) @(posedge pclk);
        #1 chk("irq", irq, {31'h0, |(e_st & e_mask)});
    endtask : chk_irq

    // Pulses one set of pipeline events for a cycle and checks the model after it.
    // Bits: 0 retire, 1 branch, 2 link, 3 linked load, 4 cond store, 5 exc return,
    // 6 trap, 7 late result, 8 store conflict, 9 set code, 10 new code.
    task automatic op(input logic [10:0] f, input logic [31:0] val);
        logic [31:0] step;
        logic ok;
        step = e_code ? pc_state_pkg::STEP_NARROW : pc_state_pkg::STEP_WIDE;
        ok = f[0] & f[4] & ~f[6] & e_resv;
        @(posedge pclk);
        {ncs, scs, sc, lr, tr, er, cs, ll, lw, br, retire} <= f;
        tgt <= val;
        erpc <= val;
        tvec <= val;
        ttype <= val[4:0];
        ldst <= val[4:0];
        @(posedge pclk);
        {ncs, scs, sc, lr, tr, er, cs, ll, lw, br, retire} <= '0;
        #1 chk("restart_valid", rvld, {31'h0, f[6] | (f[0] & f[2])});
        if (f[6]) begin
            e_pc = val;
            e_dly = 1'b0;
            e_pend = 1'b0;
            e_st[0] = 1'b1;
        end else if (f[0]) begin
            if (f[2]) chk("restart_value", rv, (e_pc + step + step) | {31'h0, e_code});
            if (e_pend) begin
                e_pc = e_tgt;
                e_dly = 1'b0;
                e_pend = 1'b0;
            end else begin
                e_pc = f[5] ? val : e_pc + step;
                e_pend = f[1] & ~f[5];
                e_tgt = val;
                e_dly = f[1] & ~f[5];
            end
            if (f[9]) e_code = f[10];
        end
        if (f[0] & f[4] & ~e_resv) e_st[1] = 1'b1;
        if (f[0] & f[3] & ~f[6]) e_resv = 1'b1;
        if (f[8] | (f[0] & f[5])) e_resv = 1'b0;
        chk("cond_store_ok", csok, {31'h0, ok});
        chk("late_write_en", lwe, {31'h0, f[7]});
        if (f[7]) chk("late_write_dest", lwd, val[4:0]);
        chk("pc", pc, e_pc);
        chk("in_delay_slot_flag", dly, e_dly);
        chk("compressed_code_select", code, e_code);
        if (!f[4]) chk("link_reservation_flag", resv, e_resv);
    endtask : op

    // Resets the design with a given strap level and clears the model.
    task automatic do_reset(input logic s);
        @(posedge pclk);
        presetn <= 1'b0;
        strap <= s;
        @(posedge pclk);
        {e_pc, e_pend, e_dly, e_resv, e_code, e_st, e_mask} = '0;
        #1 chk("pc", pc, 32'h0000_0000);
        chk("link_reservation_flag", resv, 32'h0000_0000);
        chk("compressed_code_select", code, 32'h0000_0000);
        @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        #1 chk("memory_byte_order_big", mbig, {31'h0, s});
        chk("access_byte_order_big", abig, {31'h0, s});
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        void'($urandom(32'h03b5_f048));
        {psel, penable, pwrite, paddr, pwdata, tgt, erpc, tvec, ttype, ldst} = '0;
        {ncs, scs, sc, lr, tr, er, cs, ll, lw, br, retire} = '0;
        presetn = 1'b0;
        strap = 1'b1;
        do_reset(1'b1);
        // Flip request only with both the flip bit and user mode.
        for (k = 1; k < 4; k++) begin
            apb(1'b1, pc_state_pkg::OFF_CTRL, k);
            repeat (2) @(posedge pclk);
            #1 chk("byte_order_flip_request", flip, {31'h0, k == 3});
            chk("access_byte_order_big", abig, {31'h0, k != 3});
        end
        apb(1'b1, pc_state_pkg::OFF_CTRL, 32'h0000_000C);
        apb(1'b0, pc_state_pkg::OFF_CTRL, 32'h0000_0000);
        chk("ctrl", rd, 32'h0000_000C);
        chk("narrow_float_regs_mode", narrow, 32'h0000_0000);
        chk("wide_narrow_float_regs_mode", wnarrow, 32'h0000_0001);
        apb(1'b0, 8'h1C, 32'h0000_0000);
        chk("pslverr", err, 32'h0000_0001);
        apb(1'b1, pc_state_pkg::OFF_CTRL, 32'h0000_0008);
        repeat (2) @(posedge pclk);
        #1 chk("wide_narrow_float_regs_mode", wnarrow, 32'h0000_0000);
        // Branch walk, mode switch and compressed link.
        op(11'h001, 0);
        op(11'h003, 32'h0000_0100);
        op(11'h001, 0);
        op(11'h601, 0);
        op(11'h001, 0);
        op(11'h005, 0);
        op(11'h201, 0);
        // Random mix of plain, branch, late-result and link instructions.
        for (int i = 0; i < 24; i++) begin
            v = $urandom & 32'hFFFF_FFFC;
            k = $urandom_range(3, 0);
            op(e_pend ? 11'h001 : (k == 0 ? 11'h001 : k == 1 ? 11'h003 :
               k == 2 ? 11'h081 : 11'h005), v);
        end
        apb(1'b0, pc_state_pkg::OFF_PC, 32'h0000_0000);
        chk("pc_reg", rd, e_pc);
        // Reservation set, tested, cleared, and a failing conditional store.
        op(11'h009, 0);
        op(11'h011, 0);
        op(11'h100, 0);
        op(11'h011, 0);
        op(11'h100, 0);
        chk_irq();
        apb(1'b0, pc_state_pkg::OFF_IRQ_STATUS, 32'h0000_0000);
        chk("irq_status", rd, {30'h0, e_st});
        e_st = 2'b00;
        chk_irq();
        // Trap overrides the retiring instruction; then a trap with its interrupt enabled.
        v = $urandom & 32'hFFFF_FFFC;
        op(11'h041, v);
        chk_irq();
        apb(1'b0, pc_state_pkg::OFF_TRAP, 32'h0000_0000);
        chk("trap_type", rd, {27'h0, v[4:0]});
        apb(1'b0, pc_state_pkg::OFF_IRQ_STATUS, 32'h0000_0000);
        chk("irq_status", rd, {30'h0, e_st});
        e_st = 2'b00;
        apb(1'b1, pc_state_pkg::OFF_IRQ_MASK, 32'h0000_0001);
        e_mask = 2'b01;
        op(11'h040, 32'h0000_0200);
        chk_irq();
        // Exception return drops a held reservation.
        op(11'h009, 0);
        op(11'h021, 32'h0000_0300);
        // Second reset with a little-endian strap.
        do_reset(1'b0);
        apb(1'b1, pc_state_pkg::OFF_CTRL, 32'h0000_0003);
        repeat (2) @(posedge pclk);
        #1 chk("access_byte_order_big", abig, 32'h0000_0001);
        stop_test();
    end
endmodule : test_pc_endian_mode_state
`default_nettype wire
